// File: design/frac_mask_pkg.sv
// Constants and types for the fractional rounding and address mask block
package frac_mask_pkg;
    localparam int ACC_W = 48;
    localparam int WORD_W = 32;
    localparam int MASK_W = 16;
    localparam int PROD_W = 64;
    localparam int PROD_KEEP_W = 40;
    localparam int EXT_W = 8;
    localparam int EXT_HI_LSB = 8;
    localparam int RND32_BITS = 8;
    localparam int RND16_BITS = 24;
    localparam int EXT_MASK_BIT = 5;
    localparam int EXTWORD_W = 16;
    localparam logic [15:0] MASK_UPPER_ONES = 16'hffff;
    localparam logic [31:0] ADDR_STEP = 32'h00000004;
    localparam logic [15:0] MASK_RESET = 16'hffff;
    // Operating-mode field {unsigned/signed, fraction/integer}
    localparam logic [1:0] MODE_SINT = 2'h0;
    localparam logic [1:0] MODE_UINT = 2'h2;
    // Shift factor encodings
    localparam logic [1:0] SHIFT_NONE = 2'h0;
    localparam logic [1:0] SHIFT_LEFT = 2'h1;
    localparam logic [1:0] SHIFT_RIGHT = 2'h3;
    typedef enum logic [1:0] {
        EA_INDIRECT,
        EA_POSTINC,
        EA_PREDEC,
        EA_DISP
    } ea_mode_t;
endpackage

// File: design/mask_reg_if.sv
// Interface between the datapath and the address-limit register
`timescale 1ns/1ps
interface mask_reg_if;
    logic wr;
    logic [31:0] wdata;
    logic [15:0] value;
    modport owner(input wr, input wdata, output value);
    modport user(output wr, output wdata, input value);
endinterface

// File: design/mask_reg.sv
// Address-limit register holding only its low half
`timescale 1ns/1ps
module mask_reg
    import frac_mask_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    mask_reg_if.owner bus
);
    logic [MASK_W-1:0] stored;
    logic [MASK_W-1:0] next_stored;

    always_comb begin
        next_stored = stored;
        if (bus.wr) begin
            next_stored = bus.wdata[MASK_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stored <= MASK_RESET;
        end else begin
            stored <= next_stored;
        end
    end

    assign bus.value = stored;

    a_mask_load_low: assert property (@(posedge clk) disable iff (rst)
        bus.wr |=> stored == $past(bus.wdata[MASK_W-1:0]))
        else $error("mask register did not load low half");
endmodule

// File: design/frac_mask_unit.sv
// Fractional rounding, product scaling and masked operand address unit
`timescale 1ns/1ps
module frac_mask_unit
    import frac_mask_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Mode controls
    input wire logic [1:0] MODE,
    input wire logic ROUND_SEL,
    // Accumulator store request
    input wire logic STORE_REQ,
    input wire logic [ACC_W-1:0] ACC_IN,
    output logic STORE_VALID,
    output logic [WORD_W-1:0] STORE_DATA,
    // Product request
    input wire logic PROD_REQ,
    input wire logic LONG_OPS,
    input wire logic INT_MUL,
    input wire logic [1:0] SHIFT_FACTOR,
    input wire logic [PROD_W-1:0] PRODUCT,
    output logic PROD_VALID,
    output logic [ACC_W-1:0] PROD_OUT,
    // Address-limit register access
    input wire logic MASK_WR,
    input wire logic [WORD_W-1:0] MASK_WDATA,
    output logic [WORD_W-1:0] MASK_RDATA,
    // Operand address request
    input wire logic EA_REQ,
    input wire logic [EXTWORD_W-1:0] EXT_WORD,
    input wire logic [1:0] EA_MODE,
    input wire logic [WORD_W-1:0] ADDR_REG,
    input wire logic [15:0] DISP,
    output logic EA_VALID,
    output logic [WORD_W-1:0] OPERAND_ADDR,
    output logic ADDR_UPDATE,
    output logic [WORD_W-1:0] ADDR_REG_NEW
);
    mask_reg_if mbus();
    logic frac;

    // Any code with low bit set is fractional
    function automatic logic is_frac(input logic [1:0] m);
        return m[0];
    endfunction

    // Keep upper part, bump on >half or exact half with odd lsb
    function automatic logic round_up(input logic upper_lsb, input logic guard,
                                      input logic sticky);
        return guard && (sticky || upper_lsb);
    endfunction

    assign frac = is_frac(MODE);
    assign mbus.wr = MASK_WR;
    assign mbus.wdata = MASK_WDATA;

    mask_reg u_mask (
        .clk(CLK),
        .rst(SYS_RST),
        .bus(mbus.owner)
    );

    // Accumulator store path
    logic [WORD_W-1:0] store_word;
    logic [ACC_W-1:0] frac_acc;
    logic [WORD_W-1:0] rnd32;
    logic [15:0] rnd16;

    always_comb begin
        frac_acc = ACC_IN;
        rnd32 = frac_acc[ACC_W-EXT_W-1:RND32_BITS]
              + {{(WORD_W-1){1'b0}}, round_up(frac_acc[RND32_BITS],
                 frac_acc[RND32_BITS-1], |frac_acc[RND32_BITS-2:0])};
        rnd16 = frac_acc[ACC_W-EXT_W-1:RND16_BITS]
              + {15'h0000, round_up(frac_acc[RND16_BITS],
                 frac_acc[RND16_BITS-1], |frac_acc[RND16_BITS-2:0])};
        if (!frac) begin
            store_word = ACC_IN[WORD_W-1:0];
        end else if (MODE[1]) begin
            store_word = {rnd16, 16'h0000};
        end else if (ROUND_SEL) begin
            store_word = rnd32;
        end else begin
            store_word = frac_acc[ACC_W-EXT_W-1:EXT_W];
        end
    end

    // Product path
    logic [ACC_W-1:0] prod_word;
    logic [PROD_KEEP_W-1:0] p40;
    logic [PROD_KEEP_W-1:0] prnd;
    localparam int DROP = PROD_W - PROD_KEEP_W;

    always_comb begin
        prnd = PRODUCT[PROD_W-1:DROP] + {{(PROD_KEEP_W-1){1'b0}},
               round_up(PRODUCT[DROP], PRODUCT[DROP-1], |PRODUCT[DROP-2:0])};
        if (frac && !INT_MUL && LONG_OPS) begin
            p40 = ROUND_SEL ? prnd : PRODUCT[PROD_W-1:DROP];
        end else if (frac && !INT_MUL) begin
            p40 = PRODUCT[PROD_W-1:DROP];
        end else begin
            p40 = PRODUCT[PROD_KEEP_W-1:0];
        end
        if (MODE == MODE_UINT && (INT_MUL || !frac)) begin
            prod_word = {{(ACC_W-PROD_KEEP_W){1'b0}}, p40};
        end else begin
            prod_word = {{(ACC_W-PROD_KEEP_W){p40[PROD_KEEP_W-1]}}, p40};
        end
        if (!frac && !INT_MUL) begin
            if (SHIFT_FACTOR == SHIFT_LEFT) begin
                prod_word = {prod_word[ACC_W-2:0], 1'b0};
            end else if (SHIFT_FACTOR == SHIFT_RIGHT) begin
                prod_word = {prod_word[ACC_W-1], prod_word[ACC_W-1:1]};
            end
        end
    end

    // Masked operand address path
    logic [WORD_W-1:0] mask_word;
    logic [WORD_W-1:0] sum_addr;
    logic [WORD_W-1:0] next_oa;
    logic [WORD_W-1:0] next_an;
    logic next_upd;
    logic use_mask;

    assign mask_word = {MASK_UPPER_ONES, mbus.value};
    assign use_mask = EXT_WORD[EXT_MASK_BIT];

    always_comb begin
        sum_addr = ADDR_REG;
        next_upd = 1'b0;
        case (ea_mode_t'(EA_MODE))
            EA_INDIRECT: sum_addr = ADDR_REG;
            EA_POSTINC: begin
                sum_addr = ADDR_REG + ADDR_STEP;
                next_upd = 1'b1;
            end
            EA_PREDEC: begin
                sum_addr = ADDR_REG - ADDR_STEP;
                next_upd = 1'b1;
            end
            EA_DISP: sum_addr = ADDR_REG + {{16{DISP[15]}}, DISP};
            default: sum_addr = ADDR_REG;
        endcase
        next_an = use_mask ? (sum_addr & mask_word) : sum_addr;
        if (ea_mode_t'(EA_MODE) == EA_POSTINC) begin
            next_oa = ADDR_REG;
        end else begin
            next_oa = next_an;
        end
    end

    // Output registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            STORE_VALID <= 1'b0;
            STORE_DATA <= '0;
            PROD_VALID <= 1'b0;
            PROD_OUT <= '0;
            MASK_RDATA <= {MASK_UPPER_ONES, MASK_RESET};
            EA_VALID <= 1'b0;
            OPERAND_ADDR <= '0;
            ADDR_UPDATE <= 1'b0;
            ADDR_REG_NEW <= '0;
        end else begin
            STORE_VALID <= STORE_REQ;
            STORE_DATA <= store_word;
            PROD_VALID <= PROD_REQ;
            PROD_OUT <= prod_word;
            MASK_RDATA <= {MASK_UPPER_ONES, mbus.value};
            EA_VALID <= EA_REQ;
            OPERAND_ADDR <= next_oa;
            ADDR_UPDATE <= EA_REQ && next_upd;
            ADDR_REG_NEW <= next_an;
        end
    end

    a_mask_read_ones: assert property (@(posedge CLK) disable iff (SYS_RST)
        MASK_RDATA == {MASK_UPPER_ONES, $past(mbus.value)})
        else $error("mask read value wrong");
    a_int_store_raw: assert property (@(posedge CLK) disable iff (SYS_RST)
        STORE_REQ && !MODE[0] |=> STORE_DATA == $past(ACC_IN[31:0]))
        else $error("integer store altered");
    a_frac_noround: assert property (@(posedge CLK) disable iff (SYS_RST)
        STORE_REQ && MODE == 2'h1 && !ROUND_SEL |=> STORE_DATA == $past(ACC_IN[39:8]))
        else $error("unrounded fraction store wrong");
    a_trunc_prod: assert property (@(posedge CLK) disable iff (SYS_RST)
        PROD_REQ && MODE[0] && !INT_MUL && LONG_OPS && !ROUND_SEL
        |=> PROD_OUT[39:0] == $past(PRODUCT[63:24]))
        else $error("fraction product not truncated");
    a_intmul_low: assert property (@(posedge CLK) disable iff (SYS_RST)
        PROD_REQ && INT_MUL |=> PROD_OUT[39:0] == $past(PRODUCT[39:0]))
        else $error("integer multiply used fraction path");
    a_frac_noshift: assert property (@(posedge CLK) disable iff (SYS_RST)
        PROD_REQ && MODE[0] && !INT_MUL && !LONG_OPS
        |=> PROD_OUT[39:0] == $past(PRODUCT[63:24]))
        else $error("product shifted in fraction mode");
    a_indirect_mask: assert property (@(posedge CLK) disable iff (SYS_RST)
        EA_REQ && EXT_WORD[5] && EA_MODE == 2'h0
        |=> OPERAND_ADDR == ($past(ADDR_REG) & MASK_RDATA))
        else $error("masked indirect address wrong");
    a_nomask_disp: assert property (@(posedge CLK) disable iff (SYS_RST)
        EA_REQ && !EXT_WORD[5] && EA_MODE == 2'h3
        |=> OPERAND_ADDR == $past(ADDR_REG) + {{16{$past(DISP[15])}}, $past(DISP)})
        else $error("unmasked displacement address wrong");
    a_postinc_upd: assert property (@(posedge CLK) disable iff (SYS_RST)
        EA_REQ && EXT_WORD[5] && EA_MODE == 2'h1 |=> ADDR_UPDATE
        && OPERAND_ADDR == $past(ADDR_REG)
        && ADDR_REG_NEW == (($past(ADDR_REG) + 32'h4) & MASK_RDATA))
        else $error("post-increment masking wrong");
    a_predec_upd: assert property (@(posedge CLK) disable iff (SYS_RST)
        EA_REQ && EXT_WORD[5] && EA_MODE == 2'h2 |=> ADDR_UPDATE
        && OPERAND_ADDR == ADDR_REG_NEW
        && ADDR_REG_NEW == (($past(ADDR_REG) - 32'h4) & MASK_RDATA))
        else $error("pre-decrement masking wrong");
endmodule

// File: verification/sw_model.sv
// Software side model that loads the address-limit register
`timescale 1ns/1ps
module sw_model (
    // Clock
    input wire logic clk,
    // Register write
    output logic mask_wr,
    output logic [31:0] mask_wdata
);
    initial begin
        mask_wr = 1'b0;
        mask_wdata = 32'h0;
    end
    // Released data is inverted so a stale value never matches
    task automatic write_mask(input logic [31:0] v);
        @(posedge clk);
        mask_wr <= 1'b1;
        mask_wdata <= v;
        @(posedge clk);
        mask_wr <= 1'b0;
        mask_wdata <= ~v;
    endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the fractional rounding and address mask unit
`timescale 1ns/1ps
module testbench;
    import frac_mask_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode, sf, eam, s;
    logic rsel, sreq, preq, lng, imul, ereq, mwr, sv, pv, ev, au, im, ln;
    logic [47:0] acc, po, a, e;
    logic [63:0] prod, k, t;
    logic [15:0] ext, disp, mk;
    logic [31:0] an, mwd, sd, mrd, oa, an_new, r1, r2, m, se;
    logic [31:0] seed = 32'hac8f;
    logic [64:0] ae, x;
    logic [31:0] sq[$];
    logic [47:0] pq[$];
    logic [64:0] aq[$];
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    frac_mask_unit u_dut (.CLK(clk), .SYS_RST(rst), .MODE(mode), .ROUND_SEL(rsel),
        .STORE_REQ(sreq), .ACC_IN(acc), .STORE_VALID(sv), .STORE_DATA(sd),
        .PROD_REQ(preq), .LONG_OPS(lng), .INT_MUL(imul), .SHIFT_FACTOR(sf),
        .PRODUCT(prod), .PROD_VALID(pv), .PROD_OUT(po), .MASK_WR(mwr),
        .MASK_WDATA(mwd), .MASK_RDATA(mrd), .EA_REQ(ereq), .EXT_WORD(ext),
        .EA_MODE(eam), .ADDR_REG(an), .DISP(disp), .EA_VALID(ev),
        .OPERAND_ADDR(oa), .ADDR_UPDATE(au), .ADDR_REG_NEW(an_new));
    sw_model u_sw (.clk(clk), .mask_wr(mwr), .mask_wdata(mwd));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Round half to even, dropping lo bits
    function automatic logic [63:0] rne(input logic [63:0] v, input int lo);
        logic [63:0] rem;
        logic [63:0] half;
        rem = v & ((64'h1 << lo) - 64'h1);
        half = 64'h1 << (lo - 1);
        v = v >> lo;
        return (rem > half || (rem == half && v[0])) ? v + 64'h1 : v;
    endfunction
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp48(input logic [47:0] got, input logic [47:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (sv === 1'b1) cmp32(sd, sq.pop_front(), "store");
        if (pv === 1'b1) cmp48(po, pq.pop_front(), "product");
        if (ev === 1'b1) begin
            ae = aq.pop_front();
            cmp32(oa, ae[63:32], "address");
            cmp32({31'h0, au}, {31'h0, ae[64]}, "update flag");
            if (ae[64]) cmp32(an_new, ae[31:0], "new register");
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {mode, rsel, sreq, acc, preq, lng, imul, sf, prod} = '0;
        {ereq, ext, eam, an, disp} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 cmp32(mrd, 32'hffffffff, "mask reset");
        // Stores back to back, every mode code, half-way remainders
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            r1 = xs();
            r2 = xs();
            a = {r1[15:0], r2};
            if (i[3]) a[23:0] = i[4] ? 24'h800000 : {a[23:8], 8'h80};
            k = rne({16'h0, a}, i[1] ? 24 : 8);
            if (!i[0]) sq.push_back(a[31:0]);
            else if (i[1]) sq.push_back({k[15:0], 16'h0});
            else sq.push_back(i[2] ? k[31:0] : a[39:8]);
            mode <= i[1:0];
            rsel <= i[2];
            acc <= a;
            sreq <= 1'b1;
        end
        @(posedge clk);
        sreq <= 1'b0;
        // Products: fractional rounding, integer extension and shifts
        for (int i = 0; i < 48; i++) begin
            @(posedge clk);
            r1 = xs();
            r2 = xs();
            k = {r1, r2};
            if (r1[0]) k[23:0] = 24'h800000;
            im = i[5] && i[1:0] == 2'h1;
            // Word-size fractional products truncate whatever the round bit
            ln = r2[1] || i[5];
            s = im ? 2'h0 : i[4:3];
            if (i[1:0] == 2'h2 && s == 2'h3) s = 2'h1;
            if (i[0] && !im) begin
                t = (i[2] && ln) ? rne(k, 24) : k >> 24;
                e = {{8{t[39]}}, t[39:0]};
            end else begin
                e = {{8{k[39] && i[1:0] != 2'h2}}, k[39:0]};
                if (s == 2'h1) e[40:0] = {k[39:0], 1'b0};
                if (s == 2'h3) e[39:0] = {k[39], k[39:1]};
            end
            pq.push_back(e);
            mode <= i[1:0];
            rsel <= i[2];
            sf <= s;
            imul <= im;
            lng <= ln;
            prod <= k;
            preq <= 1'b1;
        end
        @(posedge clk);
        preq <= 1'b0;
        // Mask loads, then every addressing mode with and without masking
        for (int j = 0; j < 2; j++) begin
            r1 = xs();
            u_sw.write_mask(r1);
            mk = r1[15:0];
            @(posedge clk);
            #1 cmp32(mrd, {16'hffff, mk}, "mask read");
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                r1 = xs();
                r2 = xs();
                m = i[2] ? {16'hffff, mk} : 32'hffffffff;
                se = {{16{r2[15]}}, r2[15:0]};
                case (i[1:0])
                    2'h0: x = {1'b0, r1 & m, 32'h0};
                    2'h1: x = {1'b1, r1, (r1 + 32'h4) & m};
                    2'h2: x = {1'b1, (r1 - 32'h4) & m, (r1 - 32'h4) & m};
                    default: x = {1'b0, (r1 + se) & m, 32'h0};
                endcase
                aq.push_back(x);
                r2[21] = i[2];
                ext <= r2[31:16];
                eam <= i[1:0];
                an <= r1;
                disp <= r2[15:0];
                ereq <= 1'b1;
            end
            @(posedge clk);
            ereq <= 1'b0;
        end
        // Save sequence: status zeroed first, then exact store and mask
        mode <= 2'h0;
        rsel <= 1'b0;
        @(posedge clk);
        sq.push_back(a[31:0]);
        acc <= a;
        sreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        // Restore: mask written back, saved status written last
        u_sw.write_mask(mrd);
        mode <= 2'h3;
        @(posedge clk);
        #1 cmp32(mrd, {16'hffff, mk}, "mask restore");
        repeat (4) @(posedge clk);
        cmp32(sq.size() + pq.size() + aq.size(), 32'h0, "pending results");
        give_verdict();
    end
endmodule
